//--- src/gcmli_pkg.sv
// Constants and types for the GPIO, clock-mask and live-insertion block
package gcmli_pkg;

  // ----------------------------------------------------------------
  // Pins and fields
  // ----------------------------------------------------------------
  localparam int unsigned GPIO_PINS   = 4;
  localparam int unsigned FIELD_W     = 8;
  localparam int unsigned MASK_W      = 16;
  localparam int unsigned SEL_W       = 3;
  localparam int unsigned CLK_OUTS    = 10;

  // Field selects on the configuration port
  localparam logic [2:0] SEL_OUT_SET  = 3'h0;
  localparam logic [2:0] SEL_OUT_CLR  = 3'h1;
  localparam logic [2:0] SEL_OE_SET   = 3'h2;
  localparam logic [2:0] SEL_OE_CLR   = 3'h3;
  localparam logic [2:0] SEL_IN       = 3'h4;
  localparam logic [2:0] SEL_MASK_LO  = 3'h5;
  localparam logic [2:0] SEL_MASK_HI  = 3'h6;

  // Values after reset
  localparam logic [3:0]  OE_RESET    = 4'h0;
  localparam logic [3:0]  DOUT_RESET  = 4'h0;
  localparam logic [15:0] MASK_RESET  = 16'h0000;

  // Pin roles during the mask shift and for live insertion
  localparam int unsigned PIN_SCLK    = 0;
  localparam int unsigned PIN_LOAD    = 2;
  localparam int unsigned PIN_LIVE    = 3;
  localparam logic [3:0]  SHIFT_OE    = 4'h5;

  // Mask layout
  localparam int unsigned SLOT_PAIRS  = 4;
  localparam int unsigned DEV_FIRST   = 4;
  localparam int unsigned DEV_LAST    = 8;
  localparam int unsigned FB_BIT      = 13;
  localparam int unsigned FB_CLK      = 9;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned SCLK_MAX_MHZ   = 33;
  localparam int unsigned SCLK_DIV       = (CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
  localparam logic [2:0]  TICK_LAST      = 3'(SCLK_DIV - 1);
  localparam logic [2:0]  TICK_RISE      = 3'(SCLK_DIV / 2);
  localparam logic [2:0]  TICK_SAMPLE    = 3'(SCLK_DIV / 2 - 1);
  localparam int unsigned SHIFT_STEPS    = 23;
  localparam logic [4:0]  STEP_LOAD      = 5'h00;
  localparam logic [4:0]  STEP_FIRST_BIT = 5'h01;
  localparam logic [4:0]  STEP_LAST_BIT  = 5'(MASK_W);
  localparam logic [4:0]  STEP_LAST      = 5'(SHIFT_STEPS - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GCMLI_RUN,
    GCMLI_SHIFT,
    GCMLI_HOLD
  } gcmli_phase_t;

  typedef struct packed {
    gcmli_phase_t phase;
    logic [4:0]   step;
    logic [2:0]   tick;
    logic [3:0]   oe;
    logic [3:0]   dout;
    logic [15:0]  mask;
    logic [7:0]   rdata;
    logic         halt;
  } gcmli_st_t;

endpackage

//--- src/gcmli_top.sv
// GPIO port with serial clock-mask load and live-insertion halt
`timescale 1ns/1ps
// Operation
// R01: Enable-set one turns that pin driver on
// R02: Enable-clear one tristates that pin
// R03: Reset leaves every pin input only
// R04: Input field reads live pin levels
// R05: Output-set one drives enabled pin high
// R06: Output-clear one drives enabled pin low
// R07: Output value resets zero, driven when enabled
// R08: Eight-bit fields, low four bits used
// R09: Start mask shift once secondary reset asserted
// R10: Hold secondary reset through 23-step shift
// R11: Pin 0 shift clock under 33 MHz
// R12: Pin 2 low one step, then high
// R13: Mask arrives most significant bit first
// R14: Mask bits sampled on dedicated input
// R15: Slot clock enabled if either pair bit zero
// R16: Bits 8-12 gate clocks 4-8, one disables
// R17: Bit 13 gates clock 9; 14-15 reserved
// R18: After shift, release pins, ignore mask input
// R19: Configuration write updates the clock mask
// R20: Live pin high masks I/O, memory, master
// R21: Enables revert when live pin falls
// R22: Halt drains queues, blocks completions, keeps config
// R23: Reset bit holds secondary reset until cleared
// R24: One shift clock and capture per bit
module gcmli_top (
  input  wire logic                                CLK_IN,
  input  wire logic                                RST_IN,
  input  wire logic                                CFG_WR_IN,
  input  wire logic                                CFG_RD_IN,
  input  wire logic [gcmli_pkg::SEL_W-1:0]         CFG_SEL_IN,
  input  wire logic [gcmli_pkg::FIELD_W-1:0]       CFG_WDATA_IN,
  output logic      [gcmli_pkg::FIELD_W-1:0]       CFG_RDATA_OUT,
  input  wire logic [gcmli_pkg::GPIO_PINS-1:0]     GPIO_IN,
  output logic      [gcmli_pkg::GPIO_PINS-1:0]     GPIO_OUT,
  output logic      [gcmli_pkg::GPIO_PINS-1:0]     GPIO_OE_OUT,
  input  wire logic                                CLOCK_MASK_SERIAL_IN,
  input  wire logic                                SEC_RESET_BIT_IN,
  output logic                                     SEC_RESET_N_OUT,
  output logic      [gcmli_pkg::CLK_OUTS-1:0]      SECONDARY_CLOCK_EN_OUT,
  input  wire logic                                LIVE_INSERT_EN_IN,
  input  wire logic                                CMD_IO_EN_IN,
  input  wire logic                                CMD_MEM_EN_IN,
  input  wire logic                                CMD_MASTER_EN_IN,
  output logic                                     IO_EN_OUT,
  output logic                                     MEM_EN_OUT,
  output logic                                     MASTER_EN_OUT,
  output logic                                     LIVE_HALT_OUT
);
  import gcmli_pkg::*;

  gcmli_st_t st_reg;
  gcmli_st_t st_next;
  logic      wr_sel_oe_set;
  logic      shifting;
  logic      sclk_high;
  logic      capture;
  logic      step_end;

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  function automatic logic field_hit(input logic en, input logic [2:0] sel,
                                     input logic [2:0] want);
    field_hit = en && (sel == want);
  endfunction

  // ----------------------------------------------------------------
  // Shift sequencing
  // ----------------------------------------------------------------
  // Pins stay released while primary reset is held
  assign shifting  = (st_reg.phase == GCMLI_SHIFT) && !RST_IN;
  assign step_end  = shifting && (st_reg.tick == TICK_LAST);
  // Rising edge mid-step gives the external register a full half-period of setup
  assign sclk_high = shifting && (st_reg.step >= STEP_FIRST_BIT) &&
                     (st_reg.step <= STEP_LAST_BIT) && (st_reg.tick >= TICK_RISE); // R11
  assign capture   = shifting && (st_reg.step >= STEP_FIRST_BIT) &&
                     (st_reg.step <= STEP_LAST_BIT) && (st_reg.tick == TICK_SAMPLE); // R24
  assign wr_sel_oe_set = field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OE_SET);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.halt = LIVE_INSERT_EN_IN && !st_reg.oe[PIN_LIVE] && GPIO_IN[PIN_LIVE]; // R20

    // Set and clear fields; zero bits leave state alone, upper bits unused
    if (wr_sel_oe_set) begin
      st_next.oe = st_reg.oe | CFG_WDATA_IN[3:0]; // R01 R08
    end
    if (field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OE_CLR)) begin
      st_next.oe = st_reg.oe & ~CFG_WDATA_IN[3:0]; // R02
    end
    if (field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OUT_SET)) begin
      st_next.dout = st_reg.dout | CFG_WDATA_IN[3:0]; // R05
    end
    if (field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OUT_CLR)) begin
      st_next.dout = st_reg.dout & ~CFG_WDATA_IN[3:0]; // R06
    end
    // Mask writes are ignored while the shift owns the register
    if (!shifting && field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_MASK_LO)) begin
      st_next.mask[7:0] = CFG_WDATA_IN; // R19
    end
    if (!shifting && field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_MASK_HI)) begin
      st_next.mask[15:8] = CFG_WDATA_IN; // R19
    end

    if (CFG_RD_IN) begin
      case (CFG_SEL_IN)
        SEL_OUT_SET, SEL_OUT_CLR: st_next.rdata = {4'h0, st_reg.dout};
        SEL_OE_SET, SEL_OE_CLR:   st_next.rdata = {4'h0, st_reg.oe};
        SEL_IN:                   st_next.rdata = {4'h0, GPIO_IN}; // R04
        SEL_MASK_LO:              st_next.rdata = st_reg.mask[7:0];
        SEL_MASK_HI:              st_next.rdata = st_reg.mask[15:8];
        default:                  st_next.rdata = 8'h00;
      endcase
    end

    case (st_reg.phase)
      GCMLI_RUN: begin
        if (SEC_RESET_BIT_IN) begin
          st_next.phase = GCMLI_SHIFT; // R09 R23
          st_next.step  = STEP_LOAD;
          st_next.tick  = 3'h0;
        end
      end
      GCMLI_SHIFT: begin
        st_next.tick = st_reg.tick + 3'h1;
        if (capture) begin
          st_next.mask = {st_reg.mask[14:0], CLOCK_MASK_SERIAL_IN}; // R13 R14 R24
        end
        if (step_end) begin
          st_next.tick = 3'h0;
          st_next.step = st_reg.step + 5'h01;
          if (st_reg.step == STEP_LAST) begin
            st_next.step  = STEP_LOAD;
            st_next.phase = SEC_RESET_BIT_IN ? GCMLI_HOLD : GCMLI_RUN; // R10 R18
          end
        end
      end
      GCMLI_HOLD: begin
        if (!SEC_RESET_BIT_IN) begin
          st_next.phase = GCMLI_RUN; // R23
        end
      end
      default: begin
        st_next.phase = GCMLI_HOLD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_reg.phase <= GCMLI_SHIFT; // R09
      st_reg.step  <= STEP_LOAD;
      st_reg.tick  <= 3'h0;
      st_reg.oe    <= OE_RESET; // R03
      st_reg.dout  <= DOUT_RESET; // R07
      st_reg.mask  <= MASK_RESET;
      st_reg.rdata <= 8'h00;
      st_reg.halt  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Pins and outputs
  // ----------------------------------------------------------------
  always_comb begin
    if (shifting) begin
      // Pins 1 and 3 stay released while the shift runs
      GPIO_OE_OUT = SHIFT_OE; // R11
      GPIO_OUT    = 4'h0;
      GPIO_OUT[PIN_SCLK] = sclk_high; // R11
      GPIO_OUT[PIN_LOAD] = (st_reg.step != STEP_LOAD); // R12
    end else begin
      GPIO_OE_OUT = st_reg.oe; // R18
      GPIO_OUT    = st_reg.dout & st_reg.oe; // R07
    end
  end

  assign SEC_RESET_N_OUT = (st_reg.phase == GCMLI_RUN) && !RST_IN; // R10 R23
  assign CFG_RDATA_OUT   = st_reg.rdata;

  genvar g;
  generate
    for (g = 0; g < SLOT_PAIRS; g++) begin : g_slot
      assign SECONDARY_CLOCK_EN_OUT[g] = !st_reg.mask[2*g] || !st_reg.mask[2*g+1]; // R15
    end
    for (g = DEV_FIRST; g <= DEV_LAST; g++) begin : g_dev
      assign SECONDARY_CLOCK_EN_OUT[g] = !st_reg.mask[g+DEV_FIRST]; // R16
    end
  endgenerate
  // Bits 14 and 15 feed nothing
  assign SECONDARY_CLOCK_EN_OUT[FB_CLK] = !st_reg.mask[FB_BIT]; // R17

  // Command register readback stays outside; only the internal copies are masked
  assign IO_EN_OUT     = CMD_IO_EN_IN && !st_reg.halt; // R20 R21
  assign MEM_EN_OUT    = CMD_MEM_EN_IN && !st_reg.halt; // R20 R21
  assign MASTER_EN_OUT = CMD_MASTER_EN_IN && !st_reg.halt; // R20 R21
  // Queues drain already-queued work; completions held; config still served
  assign LIVE_HALT_OUT = st_reg.halt; // R22

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  AST_OE_SET: assert property ( // R01
    wr_sel_oe_set |=> ((st_reg.oe & $past(CFG_WDATA_IN[3:0])) == $past(CFG_WDATA_IN[3:0])))
    else $error("enable set bit not applied");

  AST_OE_CLR: assert property ( // R02
    field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OE_CLR)
    |=> ((st_reg.oe & $past(CFG_WDATA_IN[3:0])) == 4'h0))
    else $error("enable clear bit not applied");

  AST_OUT_SET: assert property ( // R05
    field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OUT_SET) && !shifting
    |=> ((GPIO_OUT & st_reg.oe) == ((st_reg.dout | $past(CFG_WDATA_IN[3:0])) & st_reg.oe)))
    else $error("output set not driven");

  AST_PIN_DRIVE: assert property ( // R07
    (st_reg.phase == GCMLI_RUN) |-> (GPIO_OE_OUT == st_reg.oe && GPIO_OUT == (st_reg.dout & st_reg.oe)))
    else $error("pin drive mismatch");

  AST_IN_READ: assert property ( // R04
    field_hit(CFG_RD_IN, CFG_SEL_IN, SEL_IN) |=> (CFG_RDATA_OUT == {4'h0, $past(GPIO_IN)}))
    else $error("input field readback wrong");

  AST_LOAD_PULSE: assert property ( // R12
    (shifting && st_reg.step == STEP_LOAD && st_reg.tick == 3'h0)
    |-> (!GPIO_OUT[PIN_LOAD] && GPIO_OE_OUT[PIN_LOAD]) ##8 GPIO_OUT[PIN_LOAD])
    else $error("load pulse not one step low");

  AST_SHIFT_HOLD: assert property ( // R10
    ($rose(shifting)) |-> (!SEC_RESET_N_OUT && shifting) [*8])
    else $error("secondary reset released during shift");

  AST_CAPTURE: assert property ( // R13
    capture |=> (st_reg.mask[0] == $past(CLOCK_MASK_SERIAL_IN)
                 && st_reg.mask[15:1] == $past(st_reg.mask[14:0])))
    else $error("mask capture order wrong");

  AST_SCLK_RISE: assert property ( // R24
    capture |=> GPIO_OUT[PIN_SCLK] ##4 !GPIO_OUT[PIN_SCLK])
    else $error("shift clock edge misplaced");

  AST_BIT_HOLD: assert property ( // R23
    (st_reg.phase == GCMLI_RUN && SEC_RESET_BIT_IN) |=> (shifting && !SEC_RESET_N_OUT))
    else $error("reset bit did not start hold");

  AST_HALT_MASK: assert property ( // R20
    (LIVE_INSERT_EN_IN && !st_reg.oe[PIN_LIVE] && GPIO_IN[PIN_LIVE])
    |=> (!IO_EN_OUT && !MEM_EN_OUT && !MASTER_EN_OUT))
    else $error("enables not masked in live insertion");

  AST_RELEASE: assert property ( // R18
    (step_end && st_reg.step == STEP_LAST && !SEC_RESET_BIT_IN)
    |=> (SEC_RESET_N_OUT && GPIO_OE_OUT == st_reg.oe))
    else $error("pins or reset not released after shift");

  // ----------------------------------------------------------------
  // Field, reset, shift, mask, clock-enable and halt checks
  // ----------------------------------------------------------------
  AST_RESET_OE: assert property ( // R03
    $fell(RST_IN) |-> (st_reg.oe == OE_RESET))
    else $error("pins not input only after reset");

  AST_RESET_DOUT: assert property ( // R07
    $fell(RST_IN) |-> (st_reg.dout == DOUT_RESET))
    else $error("stored output not zero after reset");

  AST_OUT_CLR: assert property ( // R06
    field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OUT_CLR) |=> ((st_reg.dout & $past(CFG_WDATA_IN[3:0])) == 4'h0))
    else $error("output clear bit not applied");

  AST_OUT_CLR_PIN: assert property ( // R06
    field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_OUT_CLR) |=> (shifting || ((GPIO_OUT & $past(CFG_WDATA_IN[3:0])) == 4'h0)))
    else $error("cleared pin still driven high");

  AST_ZERO_WRITE: assert property ( // R01
    CFG_WR_IN && (CFG_SEL_IN < SEL_IN) && (CFG_WDATA_IN[3:0] == 4'h0)
    |=> ($stable(st_reg.oe) && $stable(st_reg.dout)))
    else $error("zero write changed pin state");

  AST_OE_EXACT: assert property ( // R08
    wr_sel_oe_set |=> (st_reg.oe == ($past(st_reg.oe) | $past(CFG_WDATA_IN[3:0]))))
    else $error("enable set touched other bits");

  AST_IN_RO: assert property ( // R04
    field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_IN) |=> ($stable(st_reg.oe) && $stable(st_reg.dout)))
    else $error("input field write changed state");

  AST_UNMAPPED: assert property ( // R08
    field_hit(CFG_RD_IN, CFG_SEL_IN, 3'h7) |=> (CFG_RDATA_OUT == 8'h00))
    else $error("unmapped read not zero");

  AST_MASK_LO: assert property ( // R19
    !shifting && field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_MASK_LO) |=> (st_reg.mask[7:0] == $past(CFG_WDATA_IN)))
    else $error("mask low write lost");

  AST_MASK_HI: assert property ( // R19
    !shifting && field_hit(CFG_WR_IN, CFG_SEL_IN, SEL_MASK_HI) |=> (st_reg.mask[15:8] == $past(CFG_WDATA_IN)))
    else $error("mask high write lost");

  AST_MASK_IDLE: assert property ( // R18
    !capture && !CFG_WR_IN |=> $stable(st_reg.mask))
    else $error("mask changed without capture or write");

  AST_START: assert property ( // R09
    $fell(RST_IN) |-> (shifting && st_reg.step == STEP_LOAD && st_reg.tick == 3'h0))
    else $error("shift did not start after reset");

  AST_SHIFT_LEN: assert property ( // R10
    $rose(shifting) |-> ##183 step_end ##1 !shifting)
    else $error("shift length wrong");

  AST_SHIFT_RESET: assert property ( // R10
    shifting |-> !SEC_RESET_N_OUT)
    else $error("secondary reset released while shifting");

  AST_SHIFT_PINS: assert property ( // R11
    shifting |-> (GPIO_OE_OUT[0] && GPIO_OE_OUT[2] && !GPIO_OE_OUT[1] && !GPIO_OE_OUT[3]))
    else $error("wrong pins driven during shift");

  AST_SCLK_HIGH: assert property ( // R11
    shifting && $rose(GPIO_OUT[PIN_SCLK]) |=> GPIO_OUT[PIN_SCLK] [*3] ##1 !GPIO_OUT[PIN_SCLK])
    else $error("shift clock high phase wrong");

  AST_SCLK_LOW: assert property ( // R11
    shifting && $fell(GPIO_OUT[PIN_SCLK]) |=> !GPIO_OUT[PIN_SCLK] [*3])
    else $error("shift clock low phase too short");

  AST_LOAD_HIGH: assert property ( // R12
    shifting && (st_reg.step != STEP_LOAD) |-> GPIO_OUT[PIN_LOAD])
    else $error("load control not high after load step");

  AST_CAPTURE_PIN: assert property ( // R24
    capture |-> (!GPIO_OUT[PIN_SCLK] && GPIO_OUT[PIN_LOAD]))
    else $error("capture outside shift clock low phase");

  AST_SLOT0: assert property ( // R15
    SECONDARY_CLOCK_EN_OUT[0] == (st_reg.mask[1:0] != 2'b11))
    else $error("slot clock enable wrong");

  AST_DEV_EN: assert property ( // R16
    SECONDARY_CLOCK_EN_OUT[8:4] == ~st_reg.mask[12:8])
    else $error("device clock enables wrong");

  AST_FB_EN: assert property ( // R17
    SECONDARY_CLOCK_EN_OUT[9] == !st_reg.mask[13])
    else $error("feedback clock enable wrong");

  AST_HOLD_BIT: assert property ( // R23
    (st_reg.phase == GCMLI_HOLD) |-> !SEC_RESET_N_OUT)
    else $error("secondary reset released while bit set");

  AST_HOLD_EXIT: assert property ( // R23
    (st_reg.phase == GCMLI_HOLD) && !SEC_RESET_BIT_IN |=> SEC_RESET_N_OUT)
    else $error("secondary reset kept after bit cleared");

  AST_REVERT: assert property ( // R21
    !(LIVE_INSERT_EN_IN && !st_reg.oe[PIN_LIVE] && GPIO_IN[PIN_LIVE])
    |=> (IO_EN_OUT == CMD_IO_EN_IN && MEM_EN_OUT == CMD_MEM_EN_IN && MASTER_EN_OUT == CMD_MASTER_EN_IN))
    else $error("enables did not revert");

endmodule

//--- tb/gcmli_shift_reg_model.sv
// External parallel-load shift register that presents the clock mask
`timescale 1ns/1ps
module gcmli_shift_reg_model (
  input  wire logic        sclk_in,
  input  wire logic        load_shift_in,
  input  wire logic [15:0] par_in,
  output logic             ser_out
);
  logic [15:0] sr_reg;
  // ----------------------------------------------------------------
  // Load and shift
  // ----------------------------------------------------------------
  // Load is level driven, so a held-low control keeps reloading
  always @(posedge sclk_in or negedge load_shift_in) begin
    if (!load_shift_in) begin
      sr_reg <= par_in;
    end else begin
      sr_reg <= {sr_reg[14:0], ~sr_reg[0]};
    end
  end
  // While the load control is low the line shows the inverse of the top bit, never a stale bit
  assign ser_out = load_shift_in ? sr_reg[15] : ~sr_reg[15];
endmodule

//--- tb/gpio_clock_mask_live_insert_bench.sv
// Self-checking bench for the GPIO, clock-mask and live-insertion block
`timescale 1ns/1ps
module gpio_clock_mask_live_insert_bench;
  import gcmli_pkg::*;
  logic       CLK_IN, RST_IN, CFG_WR_IN, CFG_RD_IN, CLOCK_MASK_SERIAL_IN;
  logic [2:0] CFG_SEL_IN;
  logic [7:0] CFG_WDATA_IN, CFG_RDATA_OUT;
  logic [3:0] GPIO_IN, GPIO_OUT, GPIO_OE_OUT, ext_lvl;
  logic       SEC_RESET_BIT_IN, SEC_RESET_N_OUT, LIVE_INSERT_EN_IN, LIVE_HALT_OUT;
  logic       CMD_IO_EN_IN, CMD_MEM_EN_IN, CMD_MASTER_EN_IN;
  logic       IO_EN_OUT, MEM_EN_OUT, MASTER_EN_OUT;
  logic [9:0] SECONDARY_CLOCK_EN_OUT;
  logic [15:0] par;
  int         errors, checked;

  // Pin level: driver wins, else the board level
  assign GPIO_IN = (GPIO_OE_OUT & GPIO_OUT) | (~GPIO_OE_OUT & ext_lvl);

  gcmli_shift_reg_model u_sreg (.sclk_in(GPIO_IN[0]), .load_shift_in(GPIO_IN[2]),
    .par_in(par), .ser_out(CLOCK_MASK_SERIAL_IN));

  gcmli_top u_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CFG_WR_IN(CFG_WR_IN),
    .CFG_RD_IN(CFG_RD_IN), .CFG_SEL_IN(CFG_SEL_IN), .CFG_WDATA_IN(CFG_WDATA_IN),
    .CFG_RDATA_OUT(CFG_RDATA_OUT), .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT),
    .GPIO_OE_OUT(GPIO_OE_OUT), .CLOCK_MASK_SERIAL_IN(CLOCK_MASK_SERIAL_IN),
    .SEC_RESET_BIT_IN(SEC_RESET_BIT_IN), .SEC_RESET_N_OUT(SEC_RESET_N_OUT),
    .SECONDARY_CLOCK_EN_OUT(SECONDARY_CLOCK_EN_OUT), .LIVE_INSERT_EN_IN(LIVE_INSERT_EN_IN),
    .CMD_IO_EN_IN(CMD_IO_EN_IN), .CMD_MEM_EN_IN(CMD_MEM_EN_IN),
    .CMD_MASTER_EN_IN(CMD_MASTER_EN_IN), .IO_EN_OUT(IO_EN_OUT), .MEM_EN_OUT(MEM_EN_OUT),
    .MASTER_EN_OUT(MASTER_EN_OUT), .LIVE_HALT_OUT(LIVE_HALT_OUT));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic bad(input string s);
    errors++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    checked++;
    if (got !== exp) bad(s);
  endtask
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cfg_wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge CLK_IN);
    CFG_WR_IN <= 1'b1; CFG_SEL_IN <= sel; CFG_WDATA_IN <= d;
    @(posedge CLK_IN);
    CFG_WR_IN <= 1'b0;
    #1;
  endtask
  task automatic cfg_rd(input logic [2:0] sel, input logic [7:0] exp, input string s);
    @(posedge CLK_IN);
    CFG_RD_IN <= 1'b1; CFG_SEL_IN <= sel;
    @(posedge CLK_IN);
    CFG_RD_IN <= 1'b0;
    #1;
    chk(CFG_RDATA_OUT, exp, s);
  endtask
  function automatic logic [9:0] exp_en(input logic [15:0] m);
    logic [9:0] e;
    for (int i = 0; i < 4; i++) e[i] = ~(m[2*i] & m[2*i+1]);
    for (int i = 0; i < 5; i++) e[4+i] = ~m[8+i];
    e[9] = ~m[13];
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Hold keeps the reset bit up past the shift, then drops it at 250
  task automatic t_shift(input logic [15:0] m, input bit hold);
    int cyc, rises, loads;
    logic p0;
    rises = 0; loads = 0; p0 = 1'b0;
    // First look is at entry, so a shift begun by reset release is seen whole
    for (cyc = 0; cyc < 400; cyc++) begin
      if (cyc > 0) @(posedge CLK_IN);
      if (hold && cyc == 250) SEC_RESET_BIT_IN <= 1'b0;
      #1;
      if (hold && cyc == 249) chk(SEC_RESET_N_OUT, 0, "released while bit set");
      if (GPIO_OE_OUT[0] && GPIO_OUT[0] && !p0) rises++;
      p0 = GPIO_OUT[0];
      if (GPIO_OE_OUT[2] && !GPIO_OUT[2]) loads++;
      if (GPIO_OE_OUT[1] || GPIO_OE_OUT[3]) bad("pin 1 or 3 driven in shift");
      if (SEC_RESET_N_OUT === 1'b1 && cyc > 8) break;
    end
    if (hold ? (cyc < 250 || cyc > 254) : (cyc < 183 || cyc > 188))
      bad("shift length off");
    checked++;
    chk(rises, 16, "shift clock count");
    chk(loads, 8, "load step length");
    chk(GPIO_OE_OUT, 0, "pins not released");
    chk(SECONDARY_CLOCK_EN_OUT, exp_en(m), "clock enables");
    cfg_rd(SEL_MASK_HI, m[15:8], "mask high");
    cfg_rd(SEL_MASK_LO, m[7:0], "mask low");
    $display("t_shift done");
  endtask

  task automatic t_regs();
    chk(GPIO_OUT, 0, "out after reset");
    cfg_wr(SEL_OUT_SET, 8'h0f);
    chk(GPIO_OUT, 0, "driven while disabled");
    cfg_rd(SEL_OUT_SET, 8'h0f, "stored out");
    cfg_wr(SEL_OE_SET, 8'hf5);
    chk(GPIO_OE_OUT, 4'h5, "oe set");
    chk(GPIO_OUT, 4'h5, "out driven");
    cfg_wr(SEL_OE_SET, 8'h00);
    cfg_wr(SEL_OUT_CLR, 8'h00);
    chk({GPIO_OE_OUT, GPIO_OUT}, 8'h55, "zero write changed state");
    cfg_wr(SEL_OUT_CLR, 8'h01);
    chk(GPIO_OUT, 4'h4, "out clear");
    cfg_wr(SEL_OE_CLR, 8'h04);
    chk({GPIO_OE_OUT, GPIO_OUT}, 8'h10, "oe clear");
    @(posedge CLK_IN);
    ext_lvl <= 4'he;
    cfg_rd(SEL_IN, 8'h0e, "input levels");
    cfg_rd(3'h7, 8'h00, "unmapped read");
    cfg_wr(SEL_OUT_SET, 8'h01);
    chk(GPIO_OUT, 4'h1, "out set");
    cfg_wr(SEL_OE_CLR, 8'hff);
    chk(GPIO_OE_OUT, 0, "all tristated");
    $display("t_regs done");
  endtask

  task automatic t_mask();
    cfg_wr(SEL_MASK_LO, 8'hc3);
    cfg_wr(SEL_MASK_HI, 8'h15);
    chk(SECONDARY_CLOCK_EN_OUT, exp_en(16'h15c3), "mask write");
    cfg_rd(SEL_MASK_HI, 8'h15, "mask readback");
    $display("t_mask done");
  endtask

  task automatic t_live();
    chk({LIVE_HALT_OUT, IO_EN_OUT, MEM_EN_OUT, MASTER_EN_OUT}, 4'h7, "halt without mode");
    @(posedge CLK_IN);
    LIVE_INSERT_EN_IN <= 1'b1;
    repeat (2) @(posedge CLK_IN);
    #1;
    chk({LIVE_HALT_OUT, IO_EN_OUT, MEM_EN_OUT, MASTER_EN_OUT}, 4'h8, "no halt");
    cfg_rd(SEL_MASK_HI, 8'h15, "config during halt");
    @(posedge CLK_IN);
    ext_lvl <= 4'h4;
    repeat (2) @(posedge CLK_IN);
    #1;
    chk({LIVE_HALT_OUT, IO_EN_OUT, MEM_EN_OUT, MASTER_EN_OUT}, 4'h7, "no revert");
    cfg_wr(SEL_OUT_SET, 8'h08);
    cfg_wr(SEL_OE_SET, 8'h08);
    repeat (2) @(posedge CLK_IN);
    #1;
    chk({LIVE_HALT_OUT, IO_EN_OUT, MEM_EN_OUT, MASTER_EN_OUT}, 4'h7, "halt on output pin");
    cfg_wr(SEL_OE_CLR, 8'h0f);
    @(posedge CLK_IN);
    LIVE_INSERT_EN_IN <= 1'b0;
    $display("t_live done");
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    CLK_IN = 1'b0;
    forever #2 CLK_IN = ~CLK_IN;
  end
  initial begin
    #80000;
    bad("watchdog");
    stop_test();
  end
  initial begin
    RST_IN = 1'b1; CFG_WR_IN = 1'b0; CFG_RD_IN = 1'b0; CFG_SEL_IN = 3'h0;
    CFG_WDATA_IN = 8'h00; ext_lvl = 4'h4; par = 16'h6db4; SEC_RESET_BIT_IN = 1'b0;
    LIVE_INSERT_EN_IN = 1'b0; CMD_IO_EN_IN = 1'b1; CMD_MEM_EN_IN = 1'b1;
    CMD_MASTER_EN_IN = 1'b1; errors = 0; checked = 0;
    repeat (16) @(posedge CLK_IN);
    #1;
    chk({SEC_RESET_N_OUT, GPIO_OE_OUT}, 0, "reset state");
    @(posedge CLK_IN);
    RST_IN <= 1'b0;
    t_shift(16'h6db4, 0);
    t_regs();
    t_mask();
    t_live();
    @(posedge CLK_IN);
    par <= 16'h9a3c;
    SEC_RESET_BIT_IN <= 1'b1;
    t_shift(16'h9a3c, 1);
    stop_test();
  end
endmodule
